// ### motion_serial_pkg.sv
// shared constants and types for the host link and the driver-chain serial port
package motion_serial_pkg;
    // host datagram layout
    localparam int DGRAM_BITS = 32;
    localparam int DATA_BITS = 24;
    localparam int STATUS_BITS = 8;
    localparam int SEL_BIT = 31;
    localparam int ADDR_HI = 30;
    localparam int ADDR_LO = 25;
    localparam int RW_BIT = 24;
    localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
    localparam int CNT_W = 6;
    // header positions while only the first byte has arrived
    localparam int HDR_SEL = SEL_BIT - RW_BIT;
    localparam int HDR_ADDR_HI = ADDR_HI - RW_BIT;
    localparam int HDR_ADDR_LO = ADDR_LO - RW_BIT;
    localparam int HDR_RW = 0;
    // reply status byte positions
    localparam int ST_IRQ = 7;
    localparam int ST_COVER = 6;
    // chain configuration table
    localparam int CFG_ENTRIES = 64;
    localparam int CFG_W = 6;
    localparam int CODE_W = 5;
    localparam int NEXT_MOTOR_FLAG = 5;
    localparam int CFG_AREA_BIT = 5;
    localparam int ODD_LO = 8;
    localparam int IDX_W = 7;
    localparam int MOTORS = 3;
    localparam int CODE_SPACE = 32;
    localparam int COVER_LEN_W = 5;
    // driver-chain half period in system clocks
    localparam int HALF_W = 9;
    localparam logic [HALF_W-1:0] HALF_MIN = 9'h008;
    localparam logic [HALF_W-1:0] HALF_MAX = 9'h100;
    localparam logic [HALF_W-1:0] HALF_DEF = 9'h010;
    // host pin synchroniser reset: select high, clock high, data low
    localparam logic [2:0] PIN_RESET = 3'h6;
    // chain sequencer states
    typedef enum logic [2:0] {
        CH_IDLE,
        CH_SETUP,
        CH_FETCH,
        CH_LOW,
        CH_HIGH,
        CH_HOLD,
        CH_GAP
    } chain_state_t;
endpackage

// ### bit_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by q_o

    // two flops per bit, constant reset value
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            meta_reg <= RESET_VAL;
            q_o <= RESET_VAL;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ### chain_clock_gen.sv
// half-period tick divider for the driver-chain serial clock
`timescale 1ns/1ps
`default_nettype none
module chain_clock_gen (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic en_i,
    input wire logic [motion_serial_pkg::HALF_W-1:0] half_i,
    output logic tick_o
);
    import motion_serial_pkg::*;

    logic [HALF_W-1:0] cnt_reg; // cycles spent in the current phase
    logic [HALF_W-1:0] half_eff; // clamped phase length

    // zero selects the default, others are held within the legal range
    assign half_eff = (half_i == '0) ? HALF_DEF : (half_i < HALF_MIN) ? HALF_MIN :
                      (half_i > HALF_MAX) ? HALF_MAX : half_i;
    assign tick_o = en_i && (cnt_reg == half_eff - 9'h001);

    // counter restarts whenever the phase ends or the sequencer pauses
    always_ff @(posedge clock_i) begin
        if (srst_i || !en_i || tick_o) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 9'h001;
        end
    end

    a_phase_min_len: assert property (@(posedge clock_i) disable iff (srst_i)
        (en_i && cnt_reg == '0) |-> !tick_o [*7])
        else $error("chain phase shorter than eight clocks");
    a_phase_default: assert property (@(posedge clock_i) disable iff (srst_i)
        (en_i && half_i == '0 && cnt_reg == 9'h00F) |-> tick_o)
        else $error("default chain phase is not sixteen clocks");
endmodule
`default_nettype wire

// ### motion_ctrl_serial_ports.sv
// host serial slave and autonomous driver-chain serial master
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_serial_ports (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic host_select_n_i,
    input wire logic host_sclk_i,
    input wire logic host_sdi_i,
    output logic host_serial_out_o,
    output logic access_o,
    output logic ram_or_register_select_o,
    output logic [motion_serial_pkg::ADDR_W-1:0] addr_o,
    output logic read_o,
    output logic [motion_serial_pkg::DATA_BITS-1:0] wr_data_o,
    input wire logic [motion_serial_pkg::DATA_BITS-1:0] rd_data_i,
    input wire logic irq_i,
    input wire logic [motion_serial_pkg::MOTORS-1:0] ref_switch_status_i,
    input wire logic [motion_serial_pkg::MOTORS-1:0] at_target_i,
    input wire logic [motion_serial_pkg::MOTORS-1:0] ref_irq_en_i,
    input wire logic [motion_serial_pkg::MOTORS-1:0] target_irq_en_i,
    input wire logic [motion_serial_pkg::MOTORS*motion_serial_pkg::CODE_SPACE-1:0] primary_bits_i,
    input wire logic send_request_i,
    input wire logic continuous_i,
    input wire logic [1:0] last_driver_index_i,
    input wire logic [motion_serial_pkg::HALF_W-1:0] chain_half_period_i,
    input wire logic chain_select_pol_i,
    input wire logic chain_clock_pol_i,
    input wire logic cover_write_i,
    input wire logic [motion_serial_pkg::DATA_BITS-1:0] cover_word_i,
    input wire logic [motion_serial_pkg::CFG_W-1:0] cover_pos_i,
    input wire logic [motion_serial_pkg::COVER_LEN_W-1:0] cover_len_i,
    output logic cover_pending_o,
    output logic chain_select_n_o,
    output logic chain_sclk_o,
    output logic chain_serial_out_o
);
    import motion_serial_pkg::*;

    // true when the address falls in the chain configuration table
    function automatic logic cfg_hit(input logic sel, input logic [ADDR_W-1:0] addr);
        cfg_hit = sel && !addr[CFG_AREA_BIT];
    endfunction

    // ---------------- host link ----------------
    logic [2:0] pins_s; // synchronised select, clock, data
    logic cs_d_reg; // select one cycle earlier
    logic sck_d_reg; // clock one cycle earlier
    logic [DGRAM_BITS-1:0] rx_reg; // request shift register
    logic [CNT_W-1:0] rx_cnt_reg; // bits received this frame
    logic hdr_done_reg; // first byte just completed
    logic [DGRAM_BITS-1:0] reply_reg; // reply word being sent
    logic [5:0] out_idx_reg; // falls still to come, 32 before the first fall
    logic [CFG_W-1:0] cfg_mem [CFG_ENTRIES]; // chain configuration table

    // host pins pass two flops before any edge logic
    bit_sync #(.WIDTH(3), .RESET_VAL(PIN_RESET)) u_pin_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .d_i({host_select_n_i, host_sclk_i, host_sdi_i}),
        .q_o(pins_s)
    );

    wire cs_s = pins_s[2];
    wire sck_s = pins_s[1];
    wire sdi_s = pins_s[0];
    wire cs_fall = !cs_s && cs_d_reg;
    wire cs_rise = cs_s && !cs_d_reg;
    wire sck_rise = sck_s && !sck_d_reg && !cs_s;
    wire sck_fall = !sck_s && sck_d_reg && !cs_s;

    // first-byte header fields
    wire h_sel = rx_reg[HDR_SEL];
    wire [ADDR_W-1:0] h_addr = rx_reg[HDR_ADDR_HI:HDR_ADDR_LO];
    wire h_read = rx_reg[HDR_RW];
    wire h_cfg = cfg_hit(h_sel, h_addr);
    // full-frame fields
    wire f_sel = rx_reg[SEL_BIT];
    wire [ADDR_W-1:0] f_addr = rx_reg[ADDR_HI:ADDR_LO];
    wire f_write = (rx_cnt_reg == CNT_W'(DGRAM_BITS)) && !rx_reg[RW_BIT];
    wire f_cfg = cfg_hit(f_sel, f_addr);
    wire frame_end = cs_rise && f_write;
    wire [CFG_W-1:0] even_idx = {h_addr[CODE_W-1:0], 1'b0};
    wire [CFG_W-1:0] wr_even = {f_addr[CODE_W-1:0], 1'b0};
    wire [DATA_BITS-1:0] cfg_rd = {10'h000, cfg_mem[even_idx | 6'h01], 2'h0, cfg_mem[even_idx]};

    // interrupt level from the status sources
    wire irq_level = irq_i || |(ref_switch_status_i & ref_irq_en_i) ||
                     |(at_target_i & target_irq_en_i);
    logic cover_status; // cover waiting or in flight
    wire [STATUS_BITS-1:0] status = {irq_level, cover_status,
        ref_switch_status_i[2], at_target_i[2], ref_switch_status_i[1], at_target_i[1],
        ref_switch_status_i[0], at_target_i[0]};

    // edge history of the synchronised pins
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cs_d_reg <= 1'b1;
            sck_d_reg <= 1'b1;
        end else begin
            cs_d_reg <= cs_s;
            sck_d_reg <= sck_s;
        end
    end

    // request bits enter on the rising host clock, msb first
    always_ff @(posedge clock_i) begin
        if (srst_i || cs_fall) begin
            rx_reg <= '0;
            rx_cnt_reg <= '0;
        end else if (sck_rise) begin
            rx_reg <= {rx_reg[DGRAM_BITS-2:0], sdi_s};
            rx_cnt_reg <= (rx_cnt_reg == '1) ? rx_cnt_reg : rx_cnt_reg + 6'h01;
        end
    end

    // header completes after the eighth rising edge
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            hdr_done_reg <= 1'b0;
        end else begin
            hdr_done_reg <= sck_rise && (rx_cnt_reg == CNT_W'(STATUS_BITS - 1));
        end
    end

    // outside accesses: reads after the header, writes at frame end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            access_o <= 1'b0;
            read_o <= 1'b0;
            ram_or_register_select_o <= 1'b0;
            addr_o <= '0;
            wr_data_o <= '0;
        end else if (hdr_done_reg && h_read && !h_cfg) begin
            access_o <= 1'b1;
            read_o <= 1'b1;
            ram_or_register_select_o <= h_sel;
            addr_o <= h_addr;
        end else if (frame_end && !f_cfg) begin
            access_o <= 1'b1;
            read_o <= 1'b0;
            ram_or_register_select_o <= f_sel;
            addr_o <= f_addr;
            wr_data_o <= rx_reg[DATA_BITS-1:0];
        end else begin
            access_o <= 1'b0;
        end
    end

    // reply: status on select fall, read data once available
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reply_reg <= '0;
        end else if (cs_fall) begin
            reply_reg <= {status, 24'h000000};
        end else if (hdr_done_reg && h_read && h_cfg) begin
            reply_reg[DATA_BITS-1:0] <= cfg_rd;
        end else if (access_o && read_o) begin
            reply_reg[DATA_BITS-1:0] <= rd_data_i;
        end
    end

    // reply bit index steps on each falling host clock, the first fall shows bit 31
    always_ff @(posedge clock_i) begin
        if (srst_i || cs_fall) begin
            out_idx_reg <= 6'h20;
        end else if (sck_fall && out_idx_reg != '0) begin
            out_idx_reg <= out_idx_reg - 6'h01;
        end
    end
    wire [4:0] out_bit = (out_idx_reg == 6'h20) ? 5'h1F : out_idx_reg[4:0]; // bit 31 until the first fall

    // pin carries the reply in frames and the inverted interrupt otherwise
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            host_serial_out_o <= 1'b1;
        end else begin
            host_serial_out_o <= cs_s ? !irq_level : reply_reg[out_bit];
        end
    end

    // configuration table written as an even/odd pair
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            for (int i = 0; i < CFG_ENTRIES; i++) begin
                cfg_mem[i] <= '0;
            end
        end else if (frame_end && f_cfg) begin
            cfg_mem[wr_even] <= rx_reg[CFG_W-1:0];
            cfg_mem[wr_even | 6'h01] <= rx_reg[ODD_LO+CFG_W-1:ODD_LO];
        end
    end

    // ---------------- driver chain ----------------
    chain_state_t state_reg; // sequencer state
    chain_state_t state_next;
    logic [IDX_W-1:0] idx_reg; // table entry being read
    logic [1:0] motor_reg; // motor whose bits are emitted
    logic [IDX_W-1:0] bit_cnt_reg; // bits sent in this datagram
    logic send_pend_reg; // new micro-step data waiting
    logic cover_pend_reg; // cover written, not yet started
    logic cover_use_reg; // cover in the current datagram
    logic [DATA_BITS-1:0] cov_word_reg; // staged cover word
    logic [CFG_W-1:0] cov_pos_reg;
    logic [COVER_LEN_W-1:0] cov_len_reg;
    logic [DATA_BITS-1:0] act_word_reg; // cover word in flight
    logic [CFG_W-1:0] act_pos_reg;
    logic [COVER_LEN_W-1:0] act_len_reg;
    logic tick; // end of a timed phase

    wire [CFG_W-1:0] entry = cfg_mem[idx_reg[CFG_W-1:0]];
    wire flag = entry[NEXT_MOTOR_FLAG];
    wire [CODE_W-1:0] code = entry[CODE_W-1:0];
    wire [1:0] last_eff = (last_driver_index_i == 2'h3) ? 2'h2 : last_driver_index_i;
    wire table_end = idx_reg[IDX_W-1];
    wire prim_bit = primary_bits_i[{motor_reg, code}];
    wire [IDX_W-1:0] rel = bit_cnt_reg - {1'b0, act_pos_reg};
    wire in_cov = cover_use_reg && (bit_cnt_reg >= {1'b0, act_pos_reg}) &&
                  (rel < {2'b00, act_len_reg});
    wire [COVER_LEN_W-1:0] cov_idx = act_len_reg - 5'h01 - rel[COVER_LEN_W-1:0];
    wire bit_next = in_cov ? act_word_reg[cov_idx] : prim_bit;
    wire trigger = send_pend_reg || cover_pend_reg || continuous_i;
    wire start = (state_reg == CH_IDLE) && trigger;
    wire timed = (state_reg != CH_IDLE) && (state_reg != CH_FETCH);
    wire sel_active = (state_next != CH_IDLE) && (state_next != CH_GAP);

    chain_clock_gen u_chain_clk (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .en_i(timed),
        .half_i(chain_half_period_i),
        .tick_o(tick)
    );

    // sequencer transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CH_IDLE: if (trigger) state_next = CH_SETUP;
            CH_SETUP: if (tick) state_next = CH_FETCH;
            CH_FETCH: begin
                if (table_end || (flag && motor_reg == last_eff)) begin
                    state_next = CH_HOLD;
                end else if (!flag) begin
                    state_next = CH_LOW;
                end
            end
            CH_LOW: if (tick) state_next = CH_HIGH;
            CH_HIGH: if (tick) state_next = CH_FETCH;
            CH_HOLD: if (tick) state_next = CH_GAP;
            CH_GAP: if (tick) state_next = CH_IDLE;
            default: state_next = CH_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg <= CH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // table walk: entry index, motor index, bit count
    always_ff @(posedge clock_i) begin
        if (srst_i || state_reg == CH_IDLE) begin
            idx_reg <= '0;
            motor_reg <= '0;
            bit_cnt_reg <= '0;
        end else if (state_reg == CH_FETCH && !table_end) begin
            idx_reg <= idx_reg + 7'h01;
            if (flag && motor_reg != last_eff) begin
                motor_reg <= motor_reg + 2'h1;
            end
        end else if (state_reg == CH_HIGH && tick) begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
        end
    end

    // demand flag: a new request wins over the clear at start
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            send_pend_reg <= 1'b0;
        end else if (send_request_i) begin
            send_pend_reg <= 1'b1;
        end else if (start) begin
            send_pend_reg <= 1'b0;
        end
    end

    // cover staging, pending and in-flight tracking
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cover_pend_reg <= 1'b0;
            cover_use_reg <= 1'b0;
            cov_word_reg <= '0;
            cov_pos_reg <= '0;
            cov_len_reg <= '0;
            act_word_reg <= '0;
            act_pos_reg <= '0;
            act_len_reg <= '0;
        end else begin
            if (cover_write_i) begin
                cover_pend_reg <= 1'b1;
                cov_word_reg <= cover_word_i;
                cov_pos_reg <= cover_pos_i;
                cov_len_reg <= cover_len_i;
            end else if (start) begin
                cover_pend_reg <= 1'b0;
            end
            if (start) begin
                cover_use_reg <= cover_pend_reg;
                act_word_reg <= cov_word_reg;
                act_pos_reg <= cov_pos_reg;
                act_len_reg <= cov_len_reg;
            end else if (state_reg == CH_GAP && tick) begin
                cover_use_reg <= 1'b0;
            end
        end
    end

    assign cover_status = cover_pend_reg || cover_use_reg;

    // chain pins, select and clock with programmable polarity
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            chain_select_n_o <= 1'b1;
            chain_sclk_o <= 1'b1;
            chain_serial_out_o <= 1'b0;
            cover_pending_o <= 1'b0;
        end else begin
            chain_select_n_o <= !(sel_active ^ chain_select_pol_i);
            chain_sclk_o <= (state_next != CH_LOW) ^ chain_clock_pol_i;
            cover_pending_o <= cover_status;
            if (state_reg == CH_FETCH && !table_end && !flag) begin
                chain_serial_out_o <= bit_next;
            end
        end
    end

    // ---------------- checks ----------------
    a_sync_edge: assert property (@(posedge clock_i) disable iff (srst_i)
        sck_rise |-> ($past(host_sclk_i, 2) && !$past(host_sclk_i, 3)))
        else $error("host clock edge seen without two-flop delay");
    a_status_byte: assert property (@(posedge clock_i) disable iff (srst_i)
        cs_fall |=> reply_reg[DGRAM_BITS-1:DATA_BITS] == $past(status))
        else $error("reply status byte wrong");
    a_idle_irq_out: assert property (@(posedge clock_i) disable iff (srst_i)
        (cs_s && $past(cs_s)) |=> host_serial_out_o == !$past(irq_level))
        else $error("idle output is not the inverted interrupt");
    a_read_data: assert property (@(posedge clock_i) disable iff (srst_i)
        (access_o && read_o) |=> reply_reg[DATA_BITS-1:0] == $past(rd_data_i))
        else $error("read data not placed in the reply");
    a_read_issue: assert property (@(posedge clock_i) disable iff (srst_i)
        (hdr_done_reg && h_read && !h_cfg) |=> (access_o && read_o && addr_o == $past(h_addr)))
        else $error("read request not issued after header");
    a_write_only: assert property (@(posedge clock_i) disable iff (srst_i)
        (access_o && !read_o) |-> (!rx_reg[RW_BIT] && wr_data_o == rx_reg[DATA_BITS-1:0]))
        else $error("write issued for a read request");
    a_cover_held: assert property (@(posedge clock_i) disable iff (srst_i)
        cover_write_i |=> cover_status [*2])
        else $error("cover pending dropped before sending");
    a_motor_limit: assert property (@(posedge clock_i) disable iff (srst_i)
        (state_reg != CH_IDLE) |-> motor_reg <= last_eff)
        else $error("motor index passed the last driver");
    a_fetch_step: assert property (@(posedge clock_i) disable iff (srst_i)
        (state_reg == CH_FETCH && !table_end && !flag) |=>
        (state_reg == CH_LOW && idx_reg == $past(idx_reg) + 7'h01))
        else $error("code entry not emitted in table order");
    a_idle_select: assert property (@(posedge clock_i) disable iff (srst_i)
        (state_reg == CH_IDLE && $past(state_reg) == CH_IDLE) |->
        chain_select_n_o == !$past(chain_select_pol_i))
        else $error("chain select not inactive while idle");
endmodule
`default_nettype wire

// ### host_link_model.sv
// host microcontroller model, master of the serial host link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    input wire logic clock_i,
    output logic host_select_n_i,
    output logic host_sclk_i,
    output logic host_sdi_i,
    input wire logic host_serial_out_o
);
    // idle link: select and clock high
    initial begin
        host_select_n_i = 1'b1;
        host_sclk_i = 1'b1;
        host_sdi_i = 1'b0;
    end
    // one link clock phase: four system clocks, 320 ns per bit
    task automatic half_bit();
        repeat (4) @(negedge clock_i);
    endtask
    // one full exchange; reply bit taken just before each rise
    task automatic xfer(input logic [31:0] req, output logic [31:0] rsp);
        host_select_n_i = 1'b0; // interrupt input masked from here on
        half_bit(); // select setup
        for (int i = 31; i >= 0; i--) begin // msb first, 32 bits
            host_sclk_i = 1'b0;
            host_sdi_i = req[i]; // zeros in unused data bits
            half_bit();
            rsp[i] = host_serial_out_o;
            host_sclk_i = 1'b1;
            half_bit();
        end
        host_select_n_i = 1'b1; // select hold
        host_sdi_i = ~host_sdi_i;
        repeat (3) half_bit();
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the host link and the driver-chain master
`timescale 1ns/1ps
`default_nettype none
module tb;
    import motion_serial_pkg::*;
    logic clock_i, srst_i, host_select_n_i, host_sclk_i, host_sdi_i, host_serial_out_o, access_o;
    logic ram_or_register_select_o, read_o, irq_i, send_request_i, continuous_i, cover_write_i;
    logic cover_pending_o, chain_select_n_o, chain_sclk_o, chain_serial_out_o;
    logic chain_select_pol_i, chain_clock_pol_i;
    logic [5:0] addr_o, cover_pos_i;
    logic [23:0] wr_data_o, rd_data_i, cover_word_i;
    logic [2:0] ref_switch_status_i, at_target_i, ref_irq_en_i, target_irq_en_i;
    logic [95:0] primary_bits_i;
    logic [1:0] last_driver_index_i;
    logic [8:0] chain_half_period_i;
    logic [4:0] cover_len_i;
    logic [31:0] req, rsp;
    logic [31:0] note_q[$]; // expected outside accesses, oldest first
    int n_fail = 0;
    int checked = 0;
    int n;
    int chain_n = 0; // chain bits taken by the drivers
    logic [63:0] chain_cap; // chain bits, first sent highest
    motion_ctrl_serial_ports i_dut (.*);
    host_link_model i_host (.*);
    // 25 MHz system clock
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watched chain-side level: 0 clock, 1 cover pending, 2 select
    function automatic logic pick(input int w);
        return (w == 0) ? chain_sclk_o : (w == 1) ? cover_pending_o : chain_select_n_o;
    endfunction
    // bounded wait for a level; running out counts as a mismatch
    task automatic wait_lvl(input int w, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            if (pick(w) === lvl) return;
            @(negedge clock_i);
        end
        chk(32'h0, 32'h1);
        tally_and_finish();
    endtask
    // length in clocks of the next phase at the given level
    task automatic measure(input int w, input logic lvl, input logic [31:0] exp);
        wait_lvl(w, lvl, 3000);
        for (n = 0; pick(w) === lvl && n < 600; n++) @(negedge clock_i);
        chk(32'(n), exp);
    endtask
    // expected status byte of a reply
    function automatic logic [7:0] stat(input logic i, input logic c);
        return {i, c, ref_switch_status_i[2], at_target_i[2], ref_switch_status_i[1], at_target_i[1],
                ref_switch_status_i[0], at_target_i[0]};
    endfunction
    // outside port watcher: each access takes the oldest note
    always @(negedge clock_i) begin
        if (access_o === 1'b1) begin
            chk({ram_or_register_select_o, addr_o, read_o, read_o ? 24'h0 : wr_data_o},
                note_q.size() ? note_q.pop_front() : 32'hX);
        end
    end
    // driver-chain receiver: takes a bit on each rising chain clock while selected
    always @(posedge chain_sclk_o) begin
        if (chain_select_n_o === 1'b0) begin
            chain_cap = {chain_cap[62:0], chain_serial_out_o};
            chain_n++;
        end
    end
    // main sequence
    initial begin
        {srst_i, irq_i, send_request_i, continuous_i, cover_write_i} = 5'h10;
        {chain_select_pol_i, chain_clock_pol_i, ref_irq_en_i, target_irq_en_i} = 8'h0;
        {rd_data_i, cover_word_i, cover_pos_i, cover_len_i, chain_half_period_i} = 68'h0;
        {ref_switch_status_i, at_target_i, last_driver_index_i} = 8'h2;
        primary_bits_i = 96'h1;
        rsp = $urandom(31);
        repeat (5) @(negedge clock_i);
        srst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        // idle output follows the inverted interrupt
        irq_i = 1'b1;
        repeat (6) @(negedge clock_i);
        chk(32'(host_serial_out_o), 32'h0);
        irq_i = 1'b0;
        repeat (6) @(negedge clock_i);
        chk(32'(host_serial_out_o), 32'h1);
        // write then read back through the outside port
        for (int k = 0; k < 3; k++) begin
            irq_i = k[0];
            target_irq_en_i = (k == 2) ? 3'h7 : 3'h0;
            ref_switch_status_i = 3'($urandom);
            at_target_i = (k == 2) ? 3'h1 : 3'($urandom);
            req = {1'b0, 6'(k * 21), 1'b0, 24'($urandom)};
            note_q.push_back(req);
            i_host.xfer(req, rsp);
            chk(rsp, {stat(k[0] | (k == 2), 1'b0), 24'h0});
            rd_data_i = 24'($urandom);
            req = {req[31:25], 1'b1, 24'h0};
            note_q.push_back(req);
            i_host.xfer(req, rsp);
            chk(rsp, {stat(k[0] | (k == 2), 1'b0), rd_data_i});
        end
        {irq_i, target_irq_en_i} = 4'h0;
        // cover word starts a chain datagram on its own
        {cover_word_i, cover_len_i} = {24'($urandom), 5'h18};
        cover_write_i = 1'b1;
        @(negedge clock_i);
        cover_write_i = 1'b0;
        req = {1'b0, 6'h3, 1'b1, 24'h0};
        note_q.push_back(req);
        i_host.xfer(req, rsp);
        chk(rsp, {stat(1'b0, 1'b1), rd_data_i});
        wait_lvl(0, 1'b1, 100);
        measure(0, 1'b0, 32'h10);
        wait_lvl(1, 1'b0, 5000);
        // cover word leads, msb first; the other 40 bits are code 0 of motor index 0
        chk(chain_cap[63:32], {cover_word_i, 8'hFF});
        chk(chain_cap[31:0], 32'hFFFFFFFF);
        chk(32'(chain_n), 32'h40);
        // inverted polarities turn both idle levels over
        {chain_select_pol_i, chain_clock_pol_i} = 2'h3;
        repeat (2) @(negedge clock_i);
        chk({chain_select_n_o, chain_sclk_o}, 32'h0);
        {chain_select_pol_i, chain_clock_pol_i} = 2'h0;
        // chain table pair written and read back without an outside access
        i_host.xfer({1'b1, 6'h01, 1'b0, 24'h002A15}, rsp);
        chk(rsp, {stat(1'b0, 1'b0), 24'h000000});
        i_host.xfer({1'b1, 6'h01, 1'b1, 24'h000000}, rsp);
        chk(rsp, {stat(1'b0, 1'b0), 24'h002A15});
        // shortest programmed phase on a demanded datagram
        chain_half_period_i = 9'h008;
        send_request_i = 1'b1;
        @(negedge clock_i);
        send_request_i = 1'b0;
        measure(0, 1'b0, 32'h8);
        // continuous mode restarts after one gap phase and one idle clock
        continuous_i = 1'b1;
        measure(2, 1'b1, 32'h9);
        chk(32'(note_q.size()), 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
